// >>> hdl/event_flag_cell.sv
/*
  One sticky event flag: set by a pulse, cleared by a pulse.
  Assumes set and clear are single-cycle pulses in the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module event_flag_cell (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic set_pulse,
  input wire logic clear_pulse,
  output logic flag
);

  logic flag_reg;
  logic flag_next;

  // Set wins over a clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (clear_pulse) begin
      flag_next = 1'b0;
    end
    if (set_pulse) begin
      flag_next = 1'b1;
    end
  end

  // Flag storage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule // event_flag_cell

`default_nettype wire

// >>> hdl/ieee488_event_status_byte.sv
/*
  Standard event flags and summary status byte of an instrument's
  status reporting. Events set the flags directly, beside the post path
  that feeds the error/event queue; the queue store, enable
  registers and sub-register trees live outside this block.
  Assumes every input except user_request_pin is on sys_clk; command
  strobes are one-cycle pulses from the command decoder.
*/
// Functional notes
// - Operation-complete request plus nothing pending sets bit 0, posts -800
// - Control-request flag, bit 1, always reads zero
// - Reading response data with nothing present or pending sets bit 2
// - Instrument-specific error sets device-fault flag, bit 3
// - Out-of-range or unsupported parameter sets execution-fault flag, bit 4
// - Syntax error, unknown header or embedded trigger sets bit 5
// - Unmasked local user-request activation sets bit 6, posts -600
// - Power-on flag bit 7 and reserved bits 8 to 15 read zero
// - Event flags are set by the event pulses; of same-cycle events only one is posted
// - Serial poll answer carries service request indication in bit 6
// - Serial poll leaves the status byte unchanged
// - Status query returns byte with master summary, altering nothing
// - Status bit 2 set while the error/event queue has entries
// - Status bit 3 set when an enabled questionable bit is set
// - Status bit 4 set while response bytes wait, clear when empty
// - Status bit 5 summarises the standard event flags
// - Status bit 6 is master summary, any reason to request service
// - Status bit 7 set when any operation status bit is set
// - Reading the standard event flags clears them all, except a flag whose event arrives in the same cycle
// - Master summary ORs bits 0-5 and 7 each ANDed with service enable
// - Event-summary enable picks which flags feed status bit 5
// - Clear-status clears flags, disarms operation-complete, pulses error queue and event register clears
`timescale 1ns/1ps
`default_nettype none

module ieee488_event_status_byte (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Command strobes from the command decoder
  input wire logic opc_command,
  input wire logic ops_pending,
  input wire logic event_flags_read,
  input wire logic status_query,
  input wire logic serial_poll,
  input wire logic clear_status,
  // Response data attempt and output queue state
  input wire logic response_read,
  input wire logic output_queue_empty,
  input wire logic response_pending,
  // Error postings from parser and instrument logic
  input wire logic ext_post_valid,
  input wire logic [1:0] ext_post_kind,
  input wire logic [15:0] ext_post_code,
  // Local user-request control and its mask
  input wire logic user_request_pin,
  input wire logic user_request_unmask,
  // Queue occupancy, enables and sub-register state
  input wire logic error_queue_nonempty,
  input wire logic [7:0] event_summary_enable,
  input wire logic [7:0] service_request_enable,
  input wire logic [15:0] questionable_event,
  input wire logic [15:0] questionable_enable,
  input wire logic [15:0] operation_event,
  // Answers
  output logic [15:0] standard_event_flags,
  output logic flags_read_valid,
  output logic [7:0] summary_status_byte,
  output logic [7:0] poll_response,
  output logic poll_valid,
  output logic [7:0] query_response,
  output logic query_valid,
  output logic service_request,
  // Error/event queue posting and clear
  output logic queue_post_valid,
  output logic [15:0] queue_post_code,
  output logic queue_clear,
  output logic event_registers_clear
);

  // ---------------------------------------------------------------
  // User-request pin synchroniser and edge detect
  // ---------------------------------------------------------------
  logic urq_meta_reg;
  logic urq_sync_reg;
  logic urq_last_reg;
  logic urq_meta_next;
  logic urq_sync_next;
  logic urq_last_next;
  logic urq_activated;

  // Two flip-flops before any logic reads the pin
  always_comb begin
    urq_meta_next = user_request_pin;
    urq_sync_next = urq_meta_reg;
    urq_last_next = urq_sync_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      urq_meta_reg <= 1'b0;
      urq_sync_reg <= 1'b0;
      urq_last_reg <= 1'b0;
    end else begin
      urq_meta_reg <= urq_meta_next;
      urq_sync_reg <= urq_sync_next;
      urq_last_reg <= urq_last_next;
    end
  end

  // Activation is a rising edge of the synchronised control, unmasked
  assign urq_activated = urq_sync_reg && !urq_last_reg
    && user_request_unmask;

  // ---------------------------------------------------------------
  // Operation-complete tracking
  // ---------------------------------------------------------------
  ieee488_status_pkg::opc_state_t opc_state_reg;
  ieee488_status_pkg::opc_state_t opc_state_next;
  logic opc_fire;

  // Armed by the command, fires once nothing is pending
  always_comb begin
    opc_state_next = opc_state_reg;
    opc_fire = 1'b0;
    case (opc_state_reg)
      ieee488_status_pkg::OPC_IDLE: begin
        if (opc_command && !ops_pending) begin
          opc_fire = 1'b1;
        end else if (opc_command) begin
          opc_state_next = ieee488_status_pkg::OPC_ARMED;
        end
      end
      ieee488_status_pkg::OPC_ARMED: begin
        if (clear_status) begin
          opc_state_next = ieee488_status_pkg::OPC_IDLE;
        end else if (!ops_pending) begin
          opc_fire = 1'b1;
          opc_state_next = ieee488_status_pkg::OPC_IDLE;
        end
      end
      default: begin
        opc_state_next = ieee488_status_pkg::OPC_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opc_state_reg <= ieee488_status_pkg::OPC_IDLE;
    end else begin
      opc_state_reg <= opc_state_next;
    end
  end

  // ---------------------------------------------------------------
  // Event detection and queue posting
  // ---------------------------------------------------------------
  logic query_fault;
  logic ext_device;
  logic ext_execution;
  logic ext_syntax;
  logic [7:0] flag_set;

  // Reading with nothing present or pending loses data
  assign query_fault = response_read && output_queue_empty
    && !response_pending;

  // Class decode of external postings
  assign ext_device = ext_post_valid
    && (ext_post_kind == ieee488_status_pkg::POST_DEVICE);
  assign ext_execution = ext_post_valid
    && (ext_post_kind == ieee488_status_pkg::POST_EXECUTION);
  assign ext_syntax = ext_post_valid
    && (ext_post_kind == ieee488_status_pkg::POST_SYNTAX);

  // Set pulses, taken from the same event sources as the queue postings
  always_comb begin
    flag_set = '0;
    flag_set[ieee488_status_pkg::BIT_OP_FINISHED] = opc_fire;
    flag_set[ieee488_status_pkg::BIT_QUERY_FAULT] = query_fault;
    flag_set[ieee488_status_pkg::BIT_DEVICE_FAULT] = ext_device;
    flag_set[ieee488_status_pkg::BIT_EXECUTION_FAULT] = ext_execution;
    flag_set[ieee488_status_pkg::BIT_SYNTAX_FAULT] = ext_syntax;
    flag_set[ieee488_status_pkg::BIT_USER_REQUEST] = urq_activated;
  end

  logic post_valid_reg;
  logic post_valid_next;
  logic [15:0] post_code_reg;
  logic [15:0] post_code_next;

  // One posting a cycle; internal events take priority
  always_comb begin
    post_valid_next = 1'b1;
    post_code_next = post_code_reg;
    if (opc_fire) begin
      post_code_next = ieee488_status_pkg::CODE_OP_COMPLETE;
    end else if (urq_activated) begin
      post_code_next = ieee488_status_pkg::CODE_USER_REQUEST;
    end else if (query_fault) begin
      post_code_next = ieee488_status_pkg::CODE_QUERY_FAULT;
    end else if (ext_post_valid) begin
      post_code_next = ext_post_code;
    end else begin
      post_valid_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      post_valid_reg <= 1'b0;
      post_code_reg <= ieee488_status_pkg::CODE_RESET;
    end else begin
      post_valid_reg <= post_valid_next;
      post_code_reg <= post_code_next;
    end
  end

  // ---------------------------------------------------------------
  // Sticky standard event flags
  // ---------------------------------------------------------------
  logic flags_clear;
  logic [7:0] flag_q;
  logic [15:0] event_word;

  // A read or clear-status empties the flags; set still wins
  assign flags_clear = event_flags_read || clear_status;

  genvar gi;
  generate
    for (gi = 0; gi < ieee488_status_pkg::FLAG_COUNT; gi++) begin : g_flag
      if (gi == ieee488_status_pkg::BIT_CONTROL_REQUEST ||
          gi == ieee488_status_pkg::BIT_POWER_ON) begin : g_zero
        assign flag_q[gi] = 1'b0;
      end else begin : g_cell
        event_flag_cell u_cell (
          .sys_clk(sys_clk),
          .rst_n(rst_n),
          .set_pulse(flag_set[gi]),
          .clear_pulse(flags_clear),
          .flag(flag_q[gi])
        );
      end
    end
  endgenerate

  // Reserved upper byte reads zero
  assign event_word = {8'h00, flag_q};

  // ---------------------------------------------------------------
  // Status byte summaries, recomputed every cycle
  // ---------------------------------------------------------------
  logic event_group_summary;
  logic questionable_summary;
  logic response_ready_summary;
  logic operation_summary;
  logic master_summary;
  logic [7:0] stb_core;
  logic [7:0] stb_full;

  assign event_group_summary =
    |(flag_q & event_summary_enable);
  assign questionable_summary =
    |(questionable_event & questionable_enable);
  assign response_ready_summary = !output_queue_empty;
  assign operation_summary = |operation_event;

  // Byte without bit 6; bits 0 and 1 are unused
  always_comb begin
    stb_core = ieee488_status_pkg::STB_RESET;
    stb_core[ieee488_status_pkg::SB_QUEUE_NONEMPTY] =
      error_queue_nonempty;
    stb_core[ieee488_status_pkg::SB_QUESTIONABLE] = questionable_summary;
    stb_core[ieee488_status_pkg::SB_RESPONSE_READY] =
      response_ready_summary;
    stb_core[ieee488_status_pkg::SB_EVENT_GROUP] = event_group_summary;
    stb_core[ieee488_status_pkg::SB_OPERATION] = operation_summary;
  end

  // Enabled reasons for service, bit 6 excluded by construction
  assign master_summary = |(stb_core & service_request_enable);

  // Full byte with master summary in bit 6
  always_comb begin
    stb_full = stb_core;
    stb_full[ieee488_status_pkg::SB_MASTER] = master_summary;
  end

  // ---------------------------------------------------------------
  // Registered answers
  // ---------------------------------------------------------------
  logic [15:0] flags_out_reg;
  logic [15:0] flags_out_next;
  logic flags_valid_reg;
  logic flags_valid_next;
  logic [7:0] stb_reg;
  logic [7:0] stb_next;
  logic [7:0] poll_reg;
  logic [7:0] poll_next;
  logic poll_valid_reg;
  logic poll_valid_next;
  logic [7:0] query_reg;
  logic [7:0] query_next;
  logic query_valid_reg;
  logic query_valid_next;
  logic srq_reg;
  logic srq_next;
  logic qclear_reg;
  logic qclear_next;

  // Capture answers; polls and queries only sample
  always_comb begin
    flags_out_next = flags_out_reg;
    flags_valid_next = event_flags_read;
    if (event_flags_read) begin
      flags_out_next = event_word;
    end
    stb_next = stb_full;
    srq_next = master_summary;
    poll_valid_next = serial_poll;
    poll_next = poll_reg;
    if (serial_poll) begin
      poll_next = stb_full;
    end
    query_valid_next = status_query;
    query_next = query_reg;
    if (status_query) begin
      query_next = stb_full;
    end
    qclear_next = clear_status;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_out_reg <= ieee488_status_pkg::EVENT_RESET;
      flags_valid_reg <= 1'b0;
      stb_reg <= ieee488_status_pkg::STB_RESET;
      poll_reg <= ieee488_status_pkg::STB_RESET;
      poll_valid_reg <= 1'b0;
      query_reg <= ieee488_status_pkg::STB_RESET;
      query_valid_reg <= 1'b0;
      srq_reg <= 1'b0;
      qclear_reg <= 1'b0;
    end else begin
      flags_out_reg <= flags_out_next;
      flags_valid_reg <= flags_valid_next;
      stb_reg <= stb_next;
      poll_reg <= poll_next;
      poll_valid_reg <= poll_valid_next;
      query_reg <= query_next;
      query_valid_reg <= query_valid_next;
      srq_reg <= srq_next;
      qclear_reg <= qclear_next;
    end
  end

  // Output wiring straight from flip-flops
  assign standard_event_flags = flags_out_reg;
  assign flags_read_valid = flags_valid_reg;
  assign summary_status_byte = stb_reg;
  assign poll_response = poll_reg;
  assign poll_valid = poll_valid_reg;
  assign query_response = query_reg;
  assign query_valid = query_valid_reg;
  assign service_request = srq_reg;
  assign queue_post_valid = post_valid_reg;
  assign queue_post_code = post_code_reg;
  assign queue_clear = qclear_reg;
  assign event_registers_clear = qclear_reg;

endmodule // ieee488_event_status_byte

`default_nettype wire

// >>> hdl/ieee488_status_pkg.sv
/*
  Constants shared by the standard event and status byte logic:
  bit positions, event codes and the kinds of posted events.
  Assumes a SystemVerilog compiler; no other package is needed.
*/
package ieee488_status_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int EVENT_W = 16;
  localparam int STB_W = 8;
  localparam int CODE_W = 16;
  localparam int QUES_W = 16;
  localparam int OPER_W = 16;

  // ---------------------------------------------------------------
  // Standard event flag positions
  // ---------------------------------------------------------------
  localparam int BIT_OP_FINISHED = 0;
  localparam int BIT_CONTROL_REQUEST = 1;
  localparam int BIT_QUERY_FAULT = 2;
  localparam int BIT_DEVICE_FAULT = 3;
  localparam int BIT_EXECUTION_FAULT = 4;
  localparam int BIT_SYNTAX_FAULT = 5;
  localparam int BIT_USER_REQUEST = 6;
  localparam int BIT_POWER_ON = 7;
  localparam int FLAG_COUNT = 8;

  // ---------------------------------------------------------------
  // Status byte positions
  // ---------------------------------------------------------------
  localparam int SB_QUEUE_NONEMPTY = 2;
  localparam int SB_QUESTIONABLE = 3;
  localparam int SB_RESPONSE_READY = 4;
  localparam int SB_EVENT_GROUP = 5;
  localparam int SB_MASTER = 6;
  localparam int SB_OPERATION = 7;

  // ---------------------------------------------------------------
  // Reset values and event codes (two's complement)
  // ---------------------------------------------------------------
  localparam logic [EVENT_W-1:0] EVENT_RESET = 16'h0000;
  localparam logic [STB_W-1:0] STB_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [CODE_W-1:0] CODE_OP_COMPLETE = 16'hfce0; // -800
  localparam logic [CODE_W-1:0] CODE_USER_REQUEST = 16'hfda8; // -600
  localparam logic [CODE_W-1:0] CODE_QUERY_FAULT = 16'hfe70; // -400

  // Class of an event posted by the parser or instrument logic
  typedef enum logic [1:0] {
    POST_DEVICE = 2'h0,
    POST_EXECUTION = 2'h1,
    POST_SYNTAX = 2'h2
  } post_kind_t;

  // Operation-complete tracking, Gray along idle -> armed
  typedef enum logic {
    OPC_IDLE = 1'b0,
    OPC_ARMED = 1'b1
  } opc_state_t;

endpackage

// >>> tb/bus_controller_model.sv
/*
  Remote bus controller: issues flag reads, serial polls and queries.
  Assumes the answer arrives one edge after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module bus_controller_model (
  input wire logic sys_clk,
  output logic event_flags_read,
  output logic serial_poll,
  output logic status_query,
  input wire logic flags_read_valid,
  input wire logic [15:0] standard_event_flags,
  input wire logic poll_valid,
  input wire logic [7:0] poll_response,
  input wire logic query_valid,
  input wire logic [7:0] query_response
);
  // Strobes idle at start
  initial begin
    event_flags_read = 1'b0;
    serial_poll = 1'b0;
    status_query = 1'b0;
  end

  // One strobe: 0 flag read, 1 poll, 2 query; answer taken next edge
  task automatic ask(input int kind, output logic vld,
                     output logic [15:0] v);
    @(posedge sys_clk);
    event_flags_read <= (kind == 0);
    serial_poll <= (kind == 1);
    status_query <= (kind == 2);
    @(posedge sys_clk);
    event_flags_read <= 1'b0;
    serial_poll <= 1'b0;
    status_query <= 1'b0;
    @(posedge sys_clk);
    vld = (kind == 0) ? flags_read_valid :
          (kind == 1) ? poll_valid : query_valid;
    v = (kind == 0) ? standard_event_flags :
        {8'h00, (kind == 1) ? poll_response : query_response};
  endtask
endmodule // bus_controller_model

`default_nettype wire

// >>> tb/event_status_properties.sv
/*
  Port-level assertions for the status block.
  Assumes sys_clk with async active-low rst_n; bound to every instance.
*/
`timescale 1ns/1ps
`default_nettype none

module event_status_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic opc_command,
  input wire logic ops_pending,
  input wire logic status_query,
  input wire logic serial_poll,
  input wire logic clear_status,
  input wire logic output_queue_empty,
  input wire logic error_queue_nonempty,
  input wire logic [7:0] service_request_enable,
  input wire logic [15:0] questionable_event,
  input wire logic [15:0] questionable_enable,
  input wire logic [15:0] operation_event,
  input wire logic [15:0] standard_event_flags,
  input wire logic flags_read_valid,
  input wire logic [7:0] summary_status_byte,
  input wire logic poll_valid,
  input wire logic query_valid,
  input wire logic service_request,
  input wire logic queue_post_valid,
  input wire logic [15:0] queue_post_code,
  input wire logic queue_clear,
  input wire logic event_registers_clear
);
  // ------------------------------------------------------------
  // Relations between commands, inputs and answers
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_queue_bit_track: assert property (
    $past(rst_n) && !$past(clear_status) |->
    summary_status_byte[2] == $past(error_queue_nonempty))
    else $error("status bit 2 wrong");
  chk_quest_bit_track: assert property (
    $past(rst_n) && !$past(clear_status) |-> summary_status_byte[3] ==
    $past(|(questionable_event & questionable_enable)))
    else $error("status bit 3 wrong");
  chk_ready_bit_track: assert property (
    $past(rst_n) && !$past(clear_status) |->
    summary_status_byte[4] == !$past(output_queue_empty))
    else $error("status bit 4 wrong");
  chk_oper_bit_track: assert property (
    $past(rst_n) && !$past(clear_status) |->
    summary_status_byte[7] == $past(|operation_event))
    else $error("status bit 7 wrong");
  chk_master_sum_form: assert property (
    $past(rst_n) && $stable(summary_status_byte) &&
    $stable(service_request_enable) |->
    summary_status_byte[6] == |(summary_status_byte &
    service_request_enable & 8'hbf) && service_request ==
    summary_status_byte[6])
    else $error("master summary wrong");
  chk_reserved_flags_zero: assert property (
    flags_read_valid |-> standard_event_flags[15:7] == 9'h000 &&
    !standard_event_flags[1])
    else $error("reserved flag bits set");
  chk_opc_post_code: assert property (
    opc_command && !ops_pending |=> queue_post_valid &&
    queue_post_code == ieee488_status_pkg::CODE_OP_COMPLETE)
    else $error("operation complete not posted");
  chk_poll_answer_next: assert property (
    serial_poll |=> poll_valid)
    else $error("poll not answered");
  chk_query_answer_next: assert property (
    status_query |=> query_valid)
    else $error("query not answered");
  chk_clear_pulses_out: assert property (
    clear_status |=> queue_clear && event_registers_clear)
    else $error("clear status not passed on");
endmodule // event_status_props

bind ieee488_event_status_byte event_status_props chk (.sys_clk, .rst_n,
  .opc_command, .ops_pending, .status_query, .serial_poll, .clear_status,
  .output_queue_empty, .error_queue_nonempty, .service_request_enable,
  .questionable_event, .questionable_enable, .operation_event,
  .standard_event_flags, .flags_read_valid, .summary_status_byte,
  .poll_valid, .query_valid, .service_request, .queue_post_valid,
  .queue_post_code, .queue_clear, .event_registers_clear);

`default_nettype wire

// >>> tb/ieee488_event_status_byte_tb_top.sv
/*
  Self-checking bench for the status block and its bus controller.
  Assumes a 200 MHz sys_clk and the checker bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none

module ieee488_event_status_byte_tb_top;
  logic sys_clk, rst_n, opc_command, ops_pending, clear_status;
  logic response_read, output_queue_empty, response_pending;
  logic ext_post_valid, user_request_pin, user_request_unmask;
  logic error_queue_nonempty, event_flags_read, status_query, serial_poll;
  logic [1:0] ext_post_kind;
  logic [15:0] ext_post_code, questionable_event, questionable_enable;
  logic [15:0] operation_event, standard_event_flags, queue_post_code;
  logic [7:0] event_summary_enable, service_request_enable;
  logic [7:0] summary_status_byte, poll_response, query_response;
  logic flags_read_valid, poll_valid, query_valid, service_request;
  logic queue_post_valid, queue_clear, event_registers_clear;
  logic [15:0] last_code, f;
  logic v;
  int failures, checks, posts;

  `define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

  // ------------------------------------------------------------
  // Design, controller model, clock and post monitor
  // ------------------------------------------------------------
  ieee488_event_status_byte uut (.sys_clk, .rst_n, .opc_command,
    .ops_pending, .event_flags_read, .status_query, .serial_poll,
    .clear_status, .response_read, .output_queue_empty, .response_pending,
    .ext_post_valid, .ext_post_kind, .ext_post_code, .user_request_pin,
    .user_request_unmask, .error_queue_nonempty, .event_summary_enable,
    .service_request_enable, .questionable_event, .questionable_enable,
    .operation_event, .standard_event_flags, .flags_read_valid,
    .summary_status_byte, .poll_response, .poll_valid, .query_response,
    .query_valid, .service_request, .queue_post_valid, .queue_post_code,
    .queue_clear, .event_registers_clear);
  bus_controller_model bus (.sys_clk, .event_flags_read, .serial_poll,
    .status_query, .flags_read_valid, .standard_event_flags, .poll_valid,
    .poll_response, .query_valid, .query_response);

  always #2.5 sys_clk = ~sys_clk;

  // Counts queue postings and keeps the last code
  always @(posedge sys_clk) begin
    if (queue_post_valid === 1'b1) begin
      posts++;
      last_code = queue_post_code;
    end
  end

  task step(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // One response-data attempt
  task rd_pulse;
    @(posedge sys_clk);
    response_read <= 1'b1;
    @(posedge sys_clk);
    response_read <= 1'b0;
    step(2);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_opc;
    bus.ask(0, v, f);
    `CHK("reset flags", 16'h0000, f)
    `CHK("reset byte", 8'h00, summary_status_byte)
    posts = 0;
    @(posedge sys_clk);
    ops_pending <= 1'b1;
    opc_command <= 1'b1;
    @(posedge sys_clk);
    opc_command <= 1'b0;
    step(3);
    `CHK("opc waits", 0, posts)
    ops_pending <= 1'b0;
    step(3);
    `CHK("opc posts", 1, posts)
    `CHK("opc code", 16'hfce0, last_code)
    opc_command <= 1'b1;
    step(1);
    opc_command <= 1'b0;
    bus.ask(0, v, f);
    `CHK("opc flag", 16'h0001, f)
    `CHK("read valid", 1'b1, v)
    bus.ask(0, v, f);
    `CHK("read clears", 16'h0000, f)
    $display("test opc done");
  endtask

  task t_ext;
    logic [15:0] want [4];
    want = '{16'h0008, 16'h0010, 16'h0020, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      ext_post_valid <= 1'b1;
      ext_post_kind <= 2'(k);
      ext_post_code <= 16'h0100 + 16'(k);
      @(posedge sys_clk);
      ext_post_valid <= 1'b0;
      step(2);
      `CHK("ext code", 16'h0100 + 16'(k), last_code)
      bus.ask(0, v, f);
      `CHK("ext flag", want[k], f)
    end
    $display("test ext done");
  endtask

  task t_query_fault;
    posts = 0;
    rd_pulse();
    `CHK("qf code", 16'hfe70, last_code)
    bus.ask(0, v, f);
    `CHK("qf flag", 16'h0004, f)
    response_pending <= 1'b1;
    rd_pulse();
    response_pending <= 1'b0;
    bus.ask(0, v, f);
    `CHK("qf pending", 16'h0000, f)
    `CHK("qf posts", 1, posts)
    $display("test query fault done");
  endtask

  task t_user;
    posts = 0;
    user_request_pin <= 1'b1;
    step(6);
    user_request_pin <= 1'b0;
    bus.ask(0, v, f);
    `CHK("masked flag", 16'h0000, f)
    user_request_unmask <= 1'b1;
    user_request_pin <= 1'b1;
    step(6);
    `CHK("user code", 16'hfda8, last_code)
    bus.ask(0, v, f);
    `CHK("user flag", 16'h0040, f)
    user_request_pin <= 1'b0;
    $display("test user done");
  endtask

  task t_summary;
    logic [15:0] qen [4];
    logic [7:0] sre [4], want [4];
    qen = '{16'h0100, 16'h0000, 16'h0100, 16'h0000};
    sre = '{8'h04, 8'h08, 8'h80, 8'h40};
    want = '{8'hdc, 8'h94, 8'hdc, 8'h94};
    error_queue_nonempty <= 1'b1;
    output_queue_empty <= 1'b0;
    operation_event <= 16'h8000;
    questionable_event <= 16'h0100;
    for (int k = 0; k < 4; k++) begin
      questionable_enable <= qen[k];
      service_request_enable <= sre[k];
      step(4);
      `CHK("status byte", want[k], summary_status_byte)
    end
    ext_post_kind <= 2'h0;
    ext_post_valid <= 1'b1;
    event_summary_enable <= 8'h10;
    step(1);
    ext_post_valid <= 1'b0;
    step(4);
    `CHK("esb masked", 8'h94, summary_status_byte)
    event_summary_enable <= 8'h08;
    questionable_enable <= 16'h0100;
    service_request_enable <= 8'h04;
    step(4);
    `CHK("esb byte", 8'hfc, summary_status_byte)
    `CHK("srq line", 1'b1, service_request)
    bus.ask(1, v, f);
    `CHK("poll byte", 16'h00fc, f)
    `CHK("poll valid", 1'b1, v)
    bus.ask(2, v, f);
    `CHK("query byte", 16'h00fc, f)
    `CHK("byte kept", 8'hfc, summary_status_byte)
    clear_status <= 1'b1;
    step(1);
    clear_status <= 1'b0;
    step(4);
    `CHK("clear esb", 1'b0, summary_status_byte[5])
    bus.ask(0, v, f);
    `CHK("clear flags", 16'h0000, f)
    $display("test summary done");
  endtask

  task final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #20000;
    failures++;
    final_report();
  end

  // Idle inputs, reset, then the scenarios in turn
  initial begin
    {sys_clk, rst_n, opc_command, ops_pending, clear_status} = '0;
    {response_read, response_pending, ext_post_valid} = '0;
    {user_request_pin, user_request_unmask, error_queue_nonempty} = '0;
    output_queue_empty = 1'b1;
    {ext_post_kind, ext_post_code, questionable_event} = '0;
    {questionable_enable, operation_event} = '0;
    {event_summary_enable, service_request_enable} = '0;
    {failures, checks, posts, last_code} = '0;
    step(2);
    rst_n <= 1'b1;
    step(4);
    t_opc();
    t_ext();
    t_query_fault();
    t_user();
    t_summary();
    final_report();
  end
endmodule // ieee488_event_status_byte_tb_top

`default_nettype wire
